// ### logic/mc_preload_pkg.sv
// Purpose: Shared constants and types of the macrocell preload scan block
// Assumes: 100 MHz reference clock, Avalon-MM register access
// Notes:   Byte addresses; each register is one aligned 32-bit word
package mc_preload_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [4:0] ADDR_CONFIG = 5'h00;
	localparam logic [4:0] ADDR_STATUS = 5'h04;
	localparam logic [4:0] ADDR_STATE  = 5'h08;
	localparam logic [4:0] ADDR_SHIFT  = 5'h0C;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CFG_SYNC_BIT   = 0;
	localparam int CFG_GLOBAL_BIT = 1;
	localparam int CFG_LOCAL_LSB  = 8;
	localparam int CFG_POL_LSB    = 16;
	localparam int ST_CLEAR_BIT   = 0;
	localparam int ST_CFGERR_BIT  = 1;
	localparam int ST_PRELOAD_BIT = 2;
	localparam int ST_BUFVAL_BIT  = 3;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic       RST_SYNC   = 1'h1;
	localparam logic       RST_GLOBAL = 1'h0;
	localparam logic [7:0] RST_LOCAL  = 8'hFF;
	localparam logic [7:0] RST_POL    = 8'h00;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_MHZ            = 100;
	localparam int CLEAR_TIME_US      = 45;
	localparam int CLEAR_CYCLES       = CLEAR_TIME_US * CLK_MHZ;
	localparam int CLEAR_CNT_W        = 13;

	// ****************************************************************
	// Buffer shape
	// ****************************************************************
	localparam int BUF_WIDTH = 1;
	localparam int BUF_DEPTH = 2;

	typedef enum logic [3:0] {
		MODE_SMALL    = 4'b0001,
		MODE_REGIST   = 4'b0010,
		MODE_MEDIUM   = 4'b0100,
		MODE_INVALID  = 4'b1000
	} arch_mode_t;
endpackage : mc_preload_pkg

// ### logic/mc_links_if.sv
// Purpose: Carriers between the preload top and its helper modules
// Assumes: Single clock domain
// Notes:   Stream carrier is used on both sides of the bit buffer
`timescale 1ns/1ns
interface arch_cfg_if;
	logic                     sync_cell;
	logic                     global_cell;
	logic [7:0]               local_cell;
	mc_preload_pkg::arch_mode_t mode;
	logic [7:0]               registered;
	logic [7:0]               always_on;
	logic [7:0]               use_term;
	logic [7:0]               use_goe;
	logic                     cfg_err;
	logic                     aux_inputs;
	modport owner   (output sync_cell, global_cell, local_cell,
	                 input mode, registered, always_on, use_term, use_goe,
	                 input cfg_err, aux_inputs);
	modport decoder (input sync_cell, global_cell, local_cell,
	                 output mode, registered, always_on, use_term,
	                 output use_goe, cfg_err, aux_inputs);
endinterface : arch_cfg_if

interface bit_stream_if;
	logic                               valid;
	logic                               ready;
	logic [mc_preload_pkg::BUF_WIDTH-1:0] data;
	modport src  (output valid, data, input ready);
	modport sink (input valid, data, output ready);
endinterface : bit_stream_if

// ### logic/arch_decode.sv
// Purpose: Turns the sync, global and local architecture cells into pin roles
// Assumes: Cells are stable register bits
// Notes:   Purely combinational
`timescale 1ns/1ns
module arch_decode (
	arch_cfg_if.decoder cfg
);
	always_comb begin
		cfg.registered = 8'h00;
		cfg.always_on  = 8'h00;
		cfg.use_term   = 8'h00;
		cfg.use_goe    = 8'h00;
		cfg.cfg_err    = 1'b0;
		// Dedicated pins follow the sync cell only
		cfg.aux_inputs = cfg.sync_cell;
		case ({cfg.sync_cell, cfg.global_cell})
			2'b10: begin
				cfg.mode      = mc_preload_pkg::MODE_SMALL;
				cfg.always_on = ~cfg.local_cell;
			end
			2'b01: begin
				cfg.mode       = mc_preload_pkg::MODE_REGIST;
				cfg.registered = ~cfg.local_cell;
				cfg.use_goe    = ~cfg.local_cell;
				cfg.use_term   = cfg.local_cell;
			end
			2'b11: begin
				cfg.mode     = mc_preload_pkg::MODE_MEDIUM;
				cfg.use_term = 8'hFF;
				cfg.cfg_err  = (cfg.local_cell != 8'hFF);
			end
			default: begin
				// No such architecture: all macrocell pins float as inputs
				cfg.mode    = mc_preload_pkg::MODE_INVALID;
				cfg.cfg_err = 1'b1;
			end
		endcase
	end
endmodule : arch_decode

// ### logic/bit_buffer.sv
// Purpose: Small FIFO between the register port and the scan chain
// Assumes: Source honours ready, sink may stall indefinitely
// Notes:   Depth two lets one bit wait while another is taken
`timescale 1ns/1ns
module bit_buffer #(
	parameter int WIDTH = mc_preload_pkg::BUF_WIDTH,
	parameter int DEPTH = mc_preload_pkg::BUF_DEPTH
) (
	input  wire logic    i_ref_clk,
	input  wire logic    i_srst,
	input  wire logic    i_ce,
	bit_stream_if.sink   up,
	bit_stream_if.src    down
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wptr_q;
	logic [PW-1:0]    rptr_q;
	logic [CW-1:0]    count_q;
	logic             push;
	logic             pop;

	assign up.ready   = (count_q != CW'(DEPTH));
	assign down.valid = (count_q != '0);
	assign down.data  = mem_q[rptr_q];
	assign push       = up.valid && up.ready;
	assign pop        = down.valid && down.ready;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	always_ff @(posedge i_ref_clk) begin
		if (i_ce && push) begin
			mem_q[wptr_q] <= up.data;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			wptr_q  <= '0;
			rptr_q  <= '0;
			count_q <= '0;
		end else if (i_ce) begin
			if (push) begin
				wptr_q <= bump(wptr_q);
			end
			if (pop) begin
				rptr_q <= bump(rptr_q);
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule : bit_buffer

// ### logic/macrocell_preload_scan.sv
// Purpose: Eight output logic macrocells with preload scan and clear
// Assumes: All pin inputs synchronous to i_ref_clk
// Notes:   Pin clocks are sampled and edge detected, not used as clocks
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module macrocell_preload_scan #(
	parameter int CLEAR_CYCLES = mc_preload_pkg::CLEAR_CYCLES
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_srst,
	input  wire logic        i_ce,
	input  wire logic [4:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic        i_preload_entry_pin,
	input  wire logic        i_preload_shift_clock,
	input  wire logic        i_serial_preload_in,
	output logic             o_serial_preload_out,
	output logic             o_serial_preload_out_oe_n,
	input  wire logic        i_clock_pin,
	input  wire logic        i_global_oe_n,
	input  wire logic [7:0]  i_logic_func,
	input  wire logic [7:0]  i_oe_term,
	input  wire logic [7:0]  i_mc_pin_in,
	output logic      [7:0]  o_mc_pin_out,
	output logic      [7:0]  o_mc_pin_oe_n,
	output logic      [15:0] o_array_lines,
	output logic             o_aux_pins_as_inputs
);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Index 0 is the lowest pin number, so data climbs upward
	function automatic logic [7:0] shift_chain(input logic [7:0] st,
	                                           input logic [7:0] regd,
	                                           input logic       din);
		logic       carry;
		logic [7:0] nxt;
		carry = din;
		nxt   = st;
		for (int i = 0; i < 8; i++) begin
			if (regd[i]) begin
				nxt[i] = carry;
				carry  = st[i];
			end
		end
		shift_chain = nxt;
	endfunction : shift_chain

	function automatic logic top_bit(input logic [7:0] st,
	                                 input logic [7:0] regd);
		logic b;
		b = 1'b1;
		for (int i = 0; i < 8; i++) begin
			if (regd[i]) begin
				b = st[i];
			end
		end
		top_bit = b;
	endfunction : top_bit

	function automatic logic apply_pol(input logic f, input logic pol);
		apply_pol = pol ? f : ~f;
	endfunction : apply_pol

	// ****************************************************************
	// Architecture cells
	// ****************************************************************
	arch_cfg_if   arch ();
	bit_stream_if buf_in ();
	bit_stream_if buf_out ();

	logic [7:0] pol_q;
	logic       sync_q;
	logic       global_q;
	logic [7:0] local_q;

	assign arch.sync_cell   = sync_q;
	assign arch.global_cell = global_q;
	assign arch.local_cell  = local_q;

	arch_decode u_decode (
		.cfg (arch.decoder)
	);

	bit_buffer u_buffer (
		.i_ref_clk (i_ref_clk),
		.i_srst    (i_srst),
		.i_ce      (i_ce),
		.up        (buf_in.sink),
		.down      (buf_out.src)
	);

	// ****************************************************************
	// Register bus
	// ****************************************************************
	localparam int CLEAR_CNT_W = mc_preload_pkg::CLEAR_CNT_W;

	logic        req;
	logic        shift_req;
	logic        go;
	logic        commit_wr;
	logic [31:0] rd_mux;
	logic [7:0]  state_q;
	logic [CLEAR_CNT_W-1:0] clr_cnt_q;
	logic        clearing;
	logic        preload_on;

	assign req       = i_avs_read || i_avs_write;
	assign shift_req = i_avs_write && (i_avs_address ==
	                   mc_preload_pkg::ADDR_SHIFT);
	// A shift write is only accepted once the buffer has room for it
	assign go        = o_avs_waitrequest && req &&
	                   (!shift_req || buf_in.ready);
	assign commit_wr = !o_avs_waitrequest && i_avs_write;

	assign buf_in.valid = commit_wr && i_avs_byteenable[0] &&
	                      (i_avs_address == mc_preload_pkg::ADDR_SHIFT);
	assign buf_in.data  = i_avs_writedata[0];

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (i_avs_address == mc_preload_pkg::ADDR_CONFIG) begin
			rd_mux[mc_preload_pkg::CFG_SYNC_BIT]   = sync_q;
			rd_mux[mc_preload_pkg::CFG_GLOBAL_BIT] = global_q;
			rd_mux[mc_preload_pkg::CFG_LOCAL_LSB +: 8] = local_q;
			rd_mux[mc_preload_pkg::CFG_POL_LSB +: 8]   = pol_q;
		end else if (i_avs_address == mc_preload_pkg::ADDR_STATUS) begin
			rd_mux[mc_preload_pkg::ST_CLEAR_BIT]   = clearing;
			rd_mux[mc_preload_pkg::ST_CFGERR_BIT]  = arch.cfg_err;
			rd_mux[mc_preload_pkg::ST_PRELOAD_BIT] = preload_on;
			rd_mux[mc_preload_pkg::ST_BUFVAL_BIT]  = buf_out.valid;
		end else if (i_avs_address == mc_preload_pkg::ADDR_STATE) begin
			rd_mux[7:0] = state_q;
		end else begin
			rd_mux = 32'h0000_0000;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= 32'h0000_0000;
		end else if (i_ce) begin
			if (!o_avs_waitrequest) begin
				o_avs_waitrequest <= 1'b1;
			end else if (go) begin
				o_avs_waitrequest <= 1'b0;
				o_avs_readdata    <= i_avs_read ? rd_mux : 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			sync_q   <= mc_preload_pkg::RST_SYNC;
			global_q <= mc_preload_pkg::RST_GLOBAL;
			local_q  <= mc_preload_pkg::RST_LOCAL;
			pol_q    <= mc_preload_pkg::RST_POL;
		end else if (i_ce && commit_wr &&
		             i_avs_address == mc_preload_pkg::ADDR_CONFIG) begin
			if (i_avs_byteenable[0]) begin
				sync_q   <= i_avs_writedata[mc_preload_pkg::CFG_SYNC_BIT];
				global_q <= i_avs_writedata[mc_preload_pkg::CFG_GLOBAL_BIT];
			end
			if (i_avs_byteenable[1]) begin
				local_q <= i_avs_writedata[mc_preload_pkg::CFG_LOCAL_LSB +: 8];
			end
			if (i_avs_byteenable[2]) begin
				pol_q <= i_avs_writedata[mc_preload_pkg::CFG_POL_LSB +: 8];
			end
		end
	end

	// ****************************************************************
	// Power-up clear
	// ****************************************************************
	assign clearing   = (clr_cnt_q != '0);
	assign preload_on = i_preload_entry_pin && !clearing;

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			clr_cnt_q <= CLEAR_CNT_W'(CLEAR_CYCLES);
		end else if (i_ce && clearing) begin
			clr_cnt_q <= clr_cnt_q - 1'b1;
		end
	end

	// ****************************************************************
	// Pin clock edges
	// ****************************************************************
	logic shclk_q;
	logic mclk_q;
	logic shift_edge;
	logic clk_edge;

	assign shift_edge = preload_on && i_preload_shift_clock && !shclk_q;
	assign clk_edge   = i_clock_pin && !mclk_q;

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			shclk_q <= 1'b0;
			mclk_q  <= 1'b0;
		end else if (i_ce) begin
			shclk_q <= i_preload_shift_clock;
			mclk_q  <= i_clock_pin;
		end
	end

	// ****************************************************************
	// Macrocell registers and scan chain
	// ****************************************************************
	// Pin shifts win; buffered bits wait, so nothing is dropped
	assign buf_out.ready = !clearing && !shift_edge;

	logic [7:0] d_in;
	always_comb begin
		d_in = 8'h00;
		for (int i = 0; i < 8; i++) begin
			// Stored value is the inverse of the wanted pin level
			d_in[i] = ~apply_pol(i_logic_func[i], pol_q[i]);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			state_q <= 8'h00;
		end else if (i_ce) begin
			if (clearing) begin
				state_q <= 8'h00;
			end else if (shift_edge) begin
				// Low level enters as 0, high as 1
				state_q <= shift_chain(state_q, arch.registered,
				                       i_serial_preload_in);
			end else if (buf_out.valid) begin
				state_q <= shift_chain(state_q, arch.registered,
				                       buf_out.data[0]);
			end else if (!preload_on && !sync_q && clk_edge) begin
				state_q <= (state_q & ~arch.registered) |
				           (d_in & arch.registered);
			end
		end
	end

	// ****************************************************************
	// Serial output, open drain
	// ****************************************************************
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_serial_preload_out      <= 1'b0;
			o_serial_preload_out_oe_n <= 1'b1;
		end else if (i_ce) begin
			o_serial_preload_out <= 1'b0;
			// Pull low only for a stored 0; a 1 relies on the pull-up
			o_serial_preload_out_oe_n <= !(preload_on &&
			    !top_bit(state_q, arch.registered));
		end
	end

	// ****************************************************************
	// Macrocell pins and array feedback
	// ****************************************************************
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_mc_pin_out         <= 8'h00;
			o_mc_pin_oe_n        <= 8'hFF;
			o_array_lines        <= 16'h0000;
			o_aux_pins_as_inputs <= 1'b1;
		end else if (i_ce) begin
			o_aux_pins_as_inputs <= arch.aux_inputs;
			for (int i = 0; i < 8; i++) begin
				if (arch.registered[i]) begin
					o_mc_pin_out[i] <= ~state_q[i];
				end else begin
					o_mc_pin_out[i] <= apply_pol(i_logic_func[i],
					                             pol_q[i]);
				end
				o_mc_pin_oe_n[i] <= !(arch.always_on[i] ||
				    (arch.use_term[i] && i_oe_term[i]) ||
				    (arch.use_goe[i] && !i_global_oe_n));
				o_array_lines[2*i]   <= i_mc_pin_in[i];
				o_array_lines[2*i+1] <= ~i_mc_pin_in[i];
			end
		end
	end
endmodule : macrocell_preload_scan

// ### sim/mc_preload_props.sv
// Purpose: Port-level checks of the macrocell preload scan block
// Assumes: One clock domain
// Notes:   Bound to the top module below the checker
`timescale 1ns/1ns
module mc_preload_props #(
	parameter int CLEAR_CYCLES = 20
) (
	input wire logic        i_ref_clk,
	input wire logic        i_srst,
	input wire logic        i_ce,
	input wire logic [4:0]  i_avs_address,
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic        o_avs_waitrequest,
	input wire logic        i_preload_entry_pin,
	input wire logic        o_serial_preload_out,
	input wire logic        o_serial_preload_out_oe_n,
	input wire logic [7:0]  i_mc_pin_in,
	input wire logic [15:0] o_array_lines
);
	logic [15:0] since_q;
	logic [15:0] lines_exp;
	logic        stat_rd;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	// ****************************************************************
	// Checks
	// ****************************************************************
	// Saturates so a long run never wraps back into the busy window
	always_ff @(posedge i_ref_clk) begin
		if (i_srst)
			since_q <= 16'h0000;
		else if (i_ce && since_q != 16'hFFFF)
			since_q <= since_q + 16'h0001;
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			lines_exp[2*i]   = i_mc_pin_in[i];
			lines_exp[2*i+1] = ~i_mc_pin_in[i];
		end
	end
	assign stat_rd = i_avs_read && !o_avs_waitrequest
		&& i_avs_address == mc_preload_pkg::ADDR_STATUS;
	sequence s_req;
		(i_avs_read || i_avs_write) && o_avs_waitrequest;
	endsequence
	sequence s_ack;
		!o_avs_waitrequest;
	endsequence
	property p_wait_bound; s_req |-> ##[0:100] s_ack; endproperty
	property p_wait_pulse; s_ack |=> o_avs_waitrequest; endproperty
	property p_wait_cause;
		s_ack |-> $past(i_avs_read || i_avs_write);
	endproperty
	property p_rdata_zero;
		s_ack ##0 (i_avs_write || i_avs_address[4]
			|| i_avs_address[1:0] != 2'h0) |-> o_avs_readdata == 32'h0;
	endproperty
	property p_sdo_low; o_serial_preload_out == 1'h0; endproperty
	property p_oe_idle;
		!i_preload_entry_pin [*3] |-> o_serial_preload_out_oe_n;
	endproperty
	// Reset loads zero lines, so the edge that leaves reset is not compared
	property p_lines;
		i_ce && !i_srst |=> o_array_lines == $past(lines_exp);
	endproperty
	property p_clear_busy;
		stat_rd && since_q < CLEAR_CYCLES - 4 |-> o_avs_readdata[0];
	endproperty
	property p_clear_done;
		stat_rd && since_q > CLEAR_CYCLES + 4 |-> !o_avs_readdata[0];
	endproperty
	a_wait_bound: assert property (p_wait_bound)
		else $error("access never answered");
	a_wait_pulse: assert property (p_wait_pulse)
		else $error("waitrequest low too long");
	a_wait_cause: assert property (p_wait_cause)
		else $error("answer without request");
	a_rdata_zero: assert property (p_rdata_zero)
		else $error("readdata not zero");
	a_sdo_low: assert property (p_sdo_low)
		else $error("serial data driven high");
	a_oe_idle: assert property (p_oe_idle)
		else $error("serial line pulled outside preload");
	a_lines: assert property (p_lines)
		else $error("array lines wrong");
	a_clear_busy: assert property (p_clear_busy)
		else $error("clear ended early");
	a_clear_done: assert property (p_clear_done)
		else $error("clear too long");
endmodule : mc_preload_props

bind macrocell_preload_scan mc_preload_props #(
	.CLEAR_CYCLES(CLEAR_CYCLES)
) u_props (
	.i_ref_clk, .i_srst, .i_ce, .i_avs_address, .i_avs_read, .i_avs_write,
	.o_avs_readdata, .o_avs_waitrequest, .i_preload_entry_pin,
	.o_serial_preload_out, .o_serial_preload_out_oe_n, .i_mc_pin_in,
	.o_array_lines
);

// ### sim/preload_tester.sv
// Purpose: Test equipment model driving the preload chain
// Assumes: Shift clock sampled by the device clock
// Notes:   Holds the fixture pull-up of the serial output
`timescale 1ns/1ns
module preload_tester (
	input  wire logic i_ref_clk,
	input  wire logic i_sdo,
	input  wire logic i_sdo_oe_n,
	output logic      o_entry,
	output logic      o_sck,
	output logic      o_sdi
);
	logic line;
	// Released line reads high through the pull-up
	assign line = i_sdo_oe_n ? 1'h1 : i_sdo;
	initial begin
		o_entry = 1'h0;
		o_sck   = 1'h0;
		o_sdi   = 1'h0;
	end
	// Sends d[n-1] first; q gets the outgoing bits in the same order
	task automatic frame(input int n, input logic [7:0] d, input int hold,
		output logic [7:0] q);
		q = 8'h00;
		@(posedge i_ref_clk);
		o_entry <= 1'h1;
		repeat (2) @(posedge i_ref_clk);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge i_ref_clk);
			o_sck <= 1'h0;
			o_sdi <= d[i];
			repeat (hold) @(posedge i_ref_clk);
			@(negedge i_ref_clk);
			q[i] = line;
			@(posedge i_ref_clk);
			o_sck <= 1'h1;
			repeat (hold + 2) @(posedge i_ref_clk);
		end
		@(posedge i_ref_clk);
		o_sck   <= 1'h0;
		o_entry <= 1'h0;
	endtask : frame
endmodule : preload_tester

// ### sim/tb_macrocell_preload_scan.sv
// Purpose: Self-checking bench of the macrocell preload scan block
// Assumes: Clear time shortened to 20 cycles
// Notes:   Clear period doubles as the far-side stall for the buffer
`timescale 1ns/1ns
module tb_macrocell_preload_scan;
	logic        clk = 1'h0;
	logic        srst = 1'h1;
	logic        ce = 1'h1;
	logic [4:0]  addr = 5'h00;
	logic        rd = 1'h0;
	logic        wr = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  be = 4'h0;
	logic        clkpin = 1'h0;
	logic        goe_n = 1'h1;
	logic [7:0]  func = 8'h00;
	logic [7:0]  oe_term = 8'h00;
	logic [7:0]  pin_in = 8'h00;
	logic [31:0] rdata, q;
	logic [7:0]  pin_out, pin_oe_n, sq;
	logic [15:0] lines;
	logic        wreq, aux, sdo, sdo_oe_n, entry, sck, sdi;
	int          errors = 0;
	int          check_count = 0;

	always #5 clk = ~clk;

	macrocell_preload_scan #(.CLEAR_CYCLES(20)) uut (
		.i_ref_clk(clk), .i_srst(srst), .i_ce(ce), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
		.i_avs_byteenable(be), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq), .i_preload_entry_pin(entry),
		.i_preload_shift_clock(sck), .i_serial_preload_in(sdi),
		.o_serial_preload_out(sdo), .o_serial_preload_out_oe_n(sdo_oe_n),
		.i_clock_pin(clkpin), .i_global_oe_n(goe_n), .i_logic_func(func),
		.i_oe_term(oe_term), .i_mc_pin_in(pin_in), .o_mc_pin_out(pin_out),
		.o_mc_pin_oe_n(pin_oe_n), .o_array_lines(lines),
		.o_aux_pins_as_inputs(aux));
	preload_tester tester (.i_ref_clk(clk), .i_sdo(sdo),
		.i_sdo_oe_n(sdo_oe_n), .o_entry(entry), .o_sck(sck), .o_sdi(sdi));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic chk(input logic [31:0] got, exp, input string m);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s %h/%h", $time, m, got, exp);
		end
	endtask : chk
	task automatic settle;
		repeat (4) @(posedge clk);
	endtask : settle
	// Holds the request until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d, input logic [3:0] b, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		rd <= ~w;
		wr <= w;
		addr <= a;
		wdata <= d;
		be <= b;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'h0 && n < 200);
		r = rdata;
		rd <= 1'h0;
		wr <= 1'h0;
		if (n >= 200)
			chk(32'h0, 32'h1, "bus hang");
	endtask : bus
	task automatic cfg(input logic s, g, input logic [7:0] l, p);
		bus(1'h1, mc_preload_pkg::ADDR_CONFIG, {8'h00, p, l, 6'h00, g, s},
			4'h7, q);
		settle();
	endtask : cfg
	task automatic st_chk(input logic [3:0] e);
		bus(1'h0, mc_preload_pkg::ADDR_STATE, 32'h0, 4'hF, q);
		chk({28'h0, q[3:0]}, {28'h0, e}, "preloaded state");
		chk({28'h0, pin_out[3:0]}, {28'h0, ~e}, "inverted pins");
	endtask : st_chk

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_buffer;
		bus(1'h1, mc_preload_pkg::ADDR_SHIFT, 32'h1, 4'hF, q);
		bus(1'h1, mc_preload_pkg::ADDR_SHIFT, 32'h0, 4'hF, q);
		bus(1'h0, mc_preload_pkg::ADDR_STATUS, 32'h0, 4'hF, q);
		chk(q, 32'h9, "clearing, bits held");
		bus(1'h1, mc_preload_pkg::ADDR_SHIFT, 32'h1, 4'hF, q);
		q = 32'hF;
		for (int n = 0; n < 8 && q !== 32'h0; n++)
			bus(1'h0, mc_preload_pkg::ADDR_STATUS, 32'h0, 4'hF, q);
		chk(q, 32'h0, "clear done, drained");
	endtask : t_buffer
	task automatic t_regs;
		bus(1'h0, mc_preload_pkg::ADDR_CONFIG, 32'h0, 4'hF, q);
		chk(q, 32'h0000FF01, "config reset");
		bus(1'h0, 5'h10, 32'h0, 4'hF, q);
		chk(q, 32'h0, "unmapped read");
		bus(1'h1, mc_preload_pkg::ADDR_STATE, 32'hFF, 4'hF, q);
		bus(1'h0, mc_preload_pkg::ADDR_STATE, 32'h0, 4'hF, q);
		chk(q, 32'h0, "state cleared, read-only");
		chk({31'h0, aux}, 32'h1, "pins as inputs");
		chk({24'h0, pin_oe_n}, 32'hFF, "all pins input");
	endtask : t_regs
	task automatic t_small;
		func <= 8'h3C;
		pin_in <= 8'h96;
		for (int k = 0; k < 2; k++) begin
			cfg(1'h1, 1'h0, 8'h0F, k ? 8'hFA : 8'h05);
			chk({24'h0, pin_oe_n}, 32'h0F, "small enables");
			chk({28'h0, pin_out[3:0]}, k ? 32'h9 : 32'h6, "polarity");
		end
		chk({16'h0, lines}, 32'h6996, "true and complement");
	endtask : t_small
	task automatic t_medium;
		cfg(1'h1, 1'h1, 8'hFE, 8'h00);
		oe_term <= 8'h81;
		bus(1'h0, mc_preload_pkg::ADDR_STATUS, 32'h0, 4'hF, q);
		chk(q, 32'h2, "medium with local 0");
		bus(1'h1, mc_preload_pkg::ADDR_CONFIG, 32'h0000FF00, 4'h2, q);
		settle();
		bus(1'h0, mc_preload_pkg::ADDR_STATUS, 32'h0, 4'hF, q);
		chk(q, 32'h0, "medium valid");
		chk({24'h0, pin_oe_n}, 32'h7E, "term enables");
	endtask : t_medium
	task automatic t_registered;
		cfg(1'h0, 1'h1, 8'hF0, 8'h00);
		goe_n <= 1'h0;
		oe_term <= 8'hC0;
		func <= 8'h5A;
		settle();
		chk({31'h0, aux}, 32'h0, "clock and enable pins");
		chk({24'h0, pin_oe_n}, 32'h30, "registered enables");
		tester.frame(4, 8'h0B, 1, sq);
		chk({28'h0, sq[3:0]}, 32'h0, "cleared state out");
		st_chk(4'hB);
		tester.frame(4, 8'h06, 4, sq);
		chk({28'h0, sq[3:0]}, 32'hB, "present state out");
		st_chk(4'h6);
		clkpin <= 1'h1;
		settle();
		chk({24'h0, pin_out & 8'hCF}, 32'h85, "normal load");
		clkpin <= 1'h0;
	endtask : t_registered

	task automatic test_done;
		if (errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'h0;
		t_buffer();
		t_regs();
		t_small();
		t_medium();
		t_registered();
		test_done();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		test_done();
	end
endmodule : tb_macrocell_preload_scan
